/* verilog/dmia_top.sv */
// Data memory address generator with pointers, indirect ports and bank select.
// Assumes an APB master for software access and a core that drives the ALU
// result, pointer increment and branch request ports synchronously.
`timescale 1ns/10ps
`default_nettype none
`include "dmia_defines.svh"

module dmia_top #(
  parameter int SECT_W = 4,
  parameter int PC_W = 15
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Arithmetic unit
  input wire logic ALU_WE,
  input wire logic [7:0] ALU_RESULT,
  output logic [7:0] ACC_OUT,
  // Pointer increments: bit 0 first, bit 1 second low, bit 2 third low
  input wire logic [2:0] PTR_INC,
  // Branch
  input wire logic BRANCH_REQ,
  input wire logic [PC_W-1:0] BRANCH_TARGET,
  output logic BRANCH_TAKEN,
  output logic [PC_W:0] PC_ADDR,
  output logic BANK_SEL
);

  localparam int RAM_AW = SECT_W + 7;

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  generate
    if (SECT_W < 1 || SECT_W > 4) begin : g_bad_sect
      $error("SECT_W must lie in 1..4 to fit a 12-bit operand");
    end
    if (PC_W < 1) begin : g_bad_pc
      $error("PC_W must be at least 1");
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [7:0] ptr1_reg;
  logic [7:0] ptr2l_reg;
  logic [7:0] ptr2h_reg;
  logic [7:0] ptr3l_reg;
  logic [7:0] ptr3h_reg;
  logic [7:0] acc_reg;
  logic bank_reg;

  dmia_mem_if #(.AW(RAM_AW)) mem_bus ();

  dmia_ram #(.AW(RAM_AW)) u_ram (
    .core_clk(CORE_CLK),
    .mem(mem_bus.mem)
  );

  // --------------------------------------------------------------------------
  // Address functions
  // --------------------------------------------------------------------------
  function automatic logic is_port(input logic [11:0] a);
    logic [7:0] off;
    off = a[7:0];
    is_port = (a[11:8] == 4'h0) &&
              (off == `DMIA_OFF_PORT1 || off == `DMIA_OFF_PORT2 || off == `DMIA_OFF_PORT3);
  endfunction

  // Unused upper sector bits are dropped so the sector stays in range
  function automatic logic [11:0] pair_addr(input logic [7:0] hi, input logic [7:0] lo);
    logic [3:0] sect;
    sect = 4'h0;
    sect[SECT_W-1:0] = hi[SECT_W-1:0];
    pair_addr = {sect, lo};
  endfunction

  function automatic logic [11:0] resolve(input logic [11:0] a);
    resolve = a;
    if (a == {4'h0, `DMIA_OFF_PORT1}) begin
      resolve = {4'h0, ptr1_reg};
    end else if (a == {4'h0, `DMIA_OFF_PORT2}) begin
      resolve = pair_addr(ptr2h_reg, ptr2l_reg);
    end else if (a == {4'h0, `DMIA_OFF_PORT3}) begin
      resolve = pair_addr(ptr3h_reg, ptr3l_reg);
    end
  endfunction

  function automatic dmia_pkg::dmia_region_t classify(input logic [11:0] a, input logic [11:0] e);
    logic [7:0] off;
    off = e[7:0];
    if (is_port(a) && is_port(e)) begin
      classify = dmia_pkg::DMIA_RG_NULL;
    end else if (int'({28'h0000000, e[11:8]}) >= (1 << SECT_W)) begin
      // Compared at full width: a narrow sector count would wrap to zero and hide every sector
      classify = dmia_pkg::DMIA_RG_UNUSED;
    end else if (off[`DMIA_GPR_BIT]) begin
      classify = dmia_pkg::DMIA_RG_RAM;
    end else if (e[11:8] != 4'h0) begin
      classify = dmia_pkg::DMIA_RG_UNUSED;
    end else if (off == `DMIA_OFF_PTR1 || off == `DMIA_OFF_PTR2L || off == `DMIA_OFF_PTR2H ||
                 off == `DMIA_OFF_ACC || off == `DMIA_OFF_BANK || off == `DMIA_OFF_PTR3L ||
                 off == `DMIA_OFF_PTR3H) begin
      classify = dmia_pkg::DMIA_RG_SFR;
    end else if (off == `DMIA_OFF_RSVD_A || off == `DMIA_OFF_RSVD_B) begin
      classify = dmia_pkg::DMIA_RG_RSVD;
    end else begin
      classify = dmia_pkg::DMIA_RG_UNUSED;
    end
  endfunction

  function automatic logic [7:0] sfr_value(input logic [7:0] off);
    case (off)
      `DMIA_OFF_PTR1: sfr_value = ptr1_reg;
      `DMIA_OFF_PTR2L: sfr_value = ptr2l_reg;
      `DMIA_OFF_PTR2H: sfr_value = ptr2h_reg;
      `DMIA_OFF_PTR3L: sfr_value = ptr3l_reg;
      `DMIA_OFF_PTR3H: sfr_value = ptr3h_reg;
      `DMIA_OFF_ACC: sfr_value = acc_reg;
      `DMIA_OFF_BANK: sfr_value = {7'h00, bank_reg};
      default: sfr_value = `DMIA_ZERO_BYTE;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  logic setup;
  logic access;
  logic addr_err;
  logic [11:0] ext_addr;
  logic [11:0] eff_now;
  dmia_pkg::dmia_region_t region_now;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign addr_err = (PADDR[31:`DMIA_APB_ADDR_HI+1] != 18'h00000) || (PADDR[1:0] != 2'h0);
  assign ext_addr = PADDR[`DMIA_APB_ADDR_HI:`DMIA_APB_ADDR_LO];
  assign eff_now = resolve(ext_addr);
  assign region_now = classify(ext_addr, eff_now);

  // Resolution is frozen at setup so a pointer change mid-transfer cannot move it
  logic [11:0] eff_reg;
  dmia_pkg::dmia_region_t region_reg;
  logic err_reg;
  logic [7:0] sfr_q_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      eff_reg <= 12'h000;
      region_reg <= dmia_pkg::DMIA_RG_UNUSED;
      err_reg <= 1'b0;
      sfr_q_reg <= 8'h00;
    end else if (setup) begin
      eff_reg <= eff_now;
      region_reg <= region_now;
      err_reg <= addr_err;
      sfr_q_reg <= (region_now == dmia_pkg::DMIA_RG_SFR) ? sfr_value(eff_now[7:0]) : `DMIA_ZERO_BYTE;
    end
  end

  logic wr_take;
  logic sfr_wr;
  logic [7:0] wbyte;

  assign wr_take = access && PWRITE && PSTRB[0] && !err_reg;
  assign sfr_wr = wr_take && (region_reg == dmia_pkg::DMIA_RG_SFR);
  assign wbyte = PWDATA[7:0];

  // Zero wait states: the read data was fetched during setup
  assign PREADY = 1'b1;
  assign PSLVERR = access && err_reg;

  always_comb begin
    PRDATA = 32'h00000000;
    if (access && !err_reg) begin
      case (region_reg)
        dmia_pkg::DMIA_RG_RAM: PRDATA = {24'h000000, mem_bus.rdata};
        dmia_pkg::DMIA_RG_SFR: PRDATA = {24'h000000, sfr_q_reg};
        dmia_pkg::DMIA_RG_RSVD: PRDATA = {24'h000000, `DMIA_RSVD_VAL};
        default: PRDATA = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // General purpose memory port
  // --------------------------------------------------------------------------
  logic [11:0] ram_ext;

  assign ram_ext = setup ? eff_now : eff_reg;
  assign mem_bus.addr = RAM_AW'({ram_ext[8+SECT_W-1:8], ram_ext[6:0]});
  assign mem_bus.wdata = wbyte;
  assign mem_bus.we = wr_take && (region_reg == dmia_pkg::DMIA_RG_RAM);

  // --------------------------------------------------------------------------
  // Pointer registers
  // --------------------------------------------------------------------------
  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = sfr_wr && (eff_reg[7:0] == off);
  endfunction

  // A software write wins over an increment in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ptr1_reg <= `DMIA_PTR_RST;
    end else if (wr_hit(`DMIA_OFF_PTR1)) begin
      ptr1_reg <= wbyte;
    end else if (PTR_INC[0]) begin
      ptr1_reg <= ptr1_reg + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ptr2l_reg <= `DMIA_PTR_RST;
    end else if (wr_hit(`DMIA_OFF_PTR2L)) begin
      ptr2l_reg <= wbyte;
    end else if (PTR_INC[1]) begin
      ptr2l_reg <= ptr2l_reg + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ptr3l_reg <= `DMIA_PTR_RST;
    end else if (wr_hit(`DMIA_OFF_PTR3L)) begin
      ptr3l_reg <= wbyte;
    end else if (PTR_INC[2]) begin
      ptr3l_reg <= ptr3l_reg + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ptr2h_reg <= `DMIA_PTR_RST;
      ptr3h_reg <= `DMIA_PTR_RST;
    end else begin
      if (wr_hit(`DMIA_OFF_PTR2H)) begin
        ptr2h_reg <= wbyte;
      end
      if (wr_hit(`DMIA_OFF_PTR3H)) begin
        ptr3h_reg <= wbyte;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Working register
  // --------------------------------------------------------------------------
  // ALU results take priority; a register-to-register copy must pass through here
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      acc_reg <= `DMIA_ACC_RST;
    end else if (ALU_WE) begin
      acc_reg <= ALU_RESULT;
    end else if (wr_hit(`DMIA_OFF_ACC)) begin
      acc_reg <= wbyte;
    end
  end

  assign ACC_OUT = acc_reg;

  // --------------------------------------------------------------------------
  // Program bank select and branch
  // --------------------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bank_reg <= `DMIA_BANK_RST;
    end else if (wr_hit(`DMIA_OFF_BANK)) begin
      bank_reg <= wbyte[`DMIA_BANK_BIT];
    end
  end

  assign BANK_SEL = bank_reg;

  // The bank is sampled at the branch; software loads it beforehand
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PC_ADDR <= '0;
      BRANCH_TAKEN <= 1'b0;
    end else begin
      BRANCH_TAKEN <= BRANCH_REQ;
      if (BRANCH_REQ) begin
        PC_ADDR <= {bank_reg, BRANCH_TARGET};
      end
    end
  end

endmodule

`default_nettype wire

/* verilog/dmia_defines.svh */
// Constants for the data memory indirect addressing block.
// Assumes 8-bit data memory, sector in the high part of a 12-bit extended address.
`ifndef DMIA_DEFINES_SVH
`define DMIA_DEFINES_SVH

// ----------------------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------------------
`define DMIA_EXT_AW 12
`define DMIA_OFF_W 8
`define DMIA_GPR_BIT 7
`define DMIA_APB_ADDR_HI 13
`define DMIA_APB_ADDR_LO 2

// ----------------------------------------------------------------------------
// Sector 0 special-function offsets
// ----------------------------------------------------------------------------
`define DMIA_OFF_PORT1 8'h00
`define DMIA_OFF_PTR1 8'h01
`define DMIA_OFF_PORT2 8'h02
`define DMIA_OFF_PTR2L 8'h03
`define DMIA_OFF_PTR2H 8'h04
`define DMIA_OFF_ACC 8'h05
`define DMIA_OFF_BANK 8'h0b
`define DMIA_OFF_PORT3 8'h0c
`define DMIA_OFF_PTR3L 8'h0d
`define DMIA_OFF_PTR3H 8'h0e
`define DMIA_OFF_RSVD_A 8'h2f
`define DMIA_OFF_RSVD_B 8'h61

// ----------------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------------
`define DMIA_PTR_RST 8'h00
`define DMIA_ACC_RST 8'h00
`define DMIA_BANK_RST 1'b0
`define DMIA_BANK_BIT 0
`define DMIA_RSVD_VAL 8'h00
`define DMIA_ZERO_BYTE 8'h00

`endif

/* verilog/dmia_pkg.sv */
// Types for the data memory indirect addressing block.
// Assumes nothing beyond the defines header.
package dmia_pkg;

  // --------------------------------------------------------------------------
  // Region of an effective address
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    DMIA_RG_RAM    = 5'b00001,
    DMIA_RG_SFR    = 5'b00010,
    DMIA_RG_NULL   = 5'b00100,
    DMIA_RG_UNUSED = 5'b01000,
    DMIA_RG_RSVD   = 5'b10000
  } dmia_region_t;

endpackage

/* verilog/dmia_mem_if.sv */
// Carrier between the address generator and the general purpose memory.
// Assumes a single clock owned by the instantiating module.
`timescale 1ns/10ps
`default_nettype none

interface dmia_mem_if #(
  parameter int AW = 11
);
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

/* verilog/dmia_ram.sv */
// General purpose data memory: offsets 80H-FFH of every sector.
// Assumes a registered read, one cycle after the address is presented.
`timescale 1ns/10ps
`default_nettype none

module dmia_ram #(
  parameter int AW = 11
) (
  // Clock
  input wire logic core_clk,
  // Memory port
  dmia_mem_if.mem mem
);

  logic [7:0] store [0:(1<<AW)-1];

  always_ff @(posedge core_clk) begin
    if (mem.we) begin
      store[mem.addr] <= mem.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    mem.rdata <= store[mem.addr];
  end

endmodule

`default_nettype wire

/* tb/dmia_top_monitor.sv */
// Port checker for the data memory address generator.
// Assumes it is bound to dmia_top and that APB stays zero wait.
`timescale 1ns/10ps
`default_nettype none
`include "dmia_defines.svh"

module dmia_top_monitor #(
  parameter int SECT_W = 4,
  parameter int PC_W = 15
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Core
  input wire logic ALU_WE,
  input wire logic [7:0] ALU_RESULT,
  input wire logic [7:0] ACC_OUT,
  input wire logic [2:0] PTR_INC,
  input wire logic BRANCH_REQ,
  input wire logic [PC_W-1:0] BRANCH_TARGET,
  input wire logic BRANCH_TAKEN,
  input wire logic [PC_W:0] PC_ADDR,
  input wire logic BANK_SEL
);
  // ----------
  // Decode
  // ----------
  logic ok;
  logic rd;
  logic wr;
  logic [11:0] ea;
  assign ok = PADDR[31:14] == 18'h0 && PADDR[1:0] == 2'h0;
  assign rd = PSEL && PENABLE && !PWRITE && ok;
  assign wr = PSEL && PENABLE && PWRITE && PSTRB[0] && ok;
  assign ea = PADDR[13:2];

  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  AST_BR_PC: assert property (
    BRANCH_REQ |=> BRANCH_TAKEN && PC_ADDR == {$past(BANK_SEL), $past(BRANCH_TARGET)})
    else $error("branch address wrong");
  AST_BR_IDLE: assert property (
    !BRANCH_REQ |=> !BRANCH_TAKEN)
    else $error("branch taken without request");
  AST_ALU: assert property (
    ALU_WE |=> ACC_OUT == $past(ALU_RESULT))
    else $error("alu result not in acc");
  AST_ACC_HOLD: assert property (
    !ALU_WE && !wr |=> $stable(ACC_OUT))
    else $error("acc changed unasked");
  AST_ACC_RD: assert property (
    rd && ea == {4'h0, `DMIA_OFF_ACC} |-> PRDATA == {24'h0, ACC_OUT})
    else $error("acc read wrong");
  AST_BANK_RD: assert property (
    rd && ea == {4'h0, `DMIA_OFF_BANK} |-> PRDATA == {31'h0, BANK_SEL})
    else $error("bank read wrong");
  AST_BANK_WR: assert property (
    wr && ea == {4'h0, `DMIA_OFF_BANK} |=> BANK_SEL == $past(PWDATA[0]))
    else $error("bank write lost");
  AST_UNUSED: assert property (
    rd && ea >= 12'h010 && ea <= 12'h07f |-> PRDATA == 32'h0)
    else $error("unused location not zero");
  cover property (BRANCH_REQ && BANK_SEL);
  cover property (ALU_WE);
  cover property (wr && ea == {4'h0, `DMIA_OFF_BANK});
  cover property (PSEL && PENABLE && PSLVERR);
endmodule

bind dmia_top dmia_top_monitor #(.SECT_W(SECT_W), .PC_W(PC_W)) dmia_top_monitor_inst (
  .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .ALU_WE(ALU_WE), .ALU_RESULT(ALU_RESULT), .ACC_OUT(ACC_OUT),
  .PTR_INC(PTR_INC), .BRANCH_REQ(BRANCH_REQ), .BRANCH_TARGET(BRANCH_TARGET),
  .BRANCH_TAKEN(BRANCH_TAKEN), .PC_ADDR(PC_ADDR), .BANK_SEL(BANK_SEL));

`default_nettype wire

/* tb/dmia_top_tb.sv */
// Self-checking bench for dmia_top over APB and the core ports.
// Assumes the monitor is bound in and the default parameters.
`timescale 1ns/10ps
`default_nettype none

module dmia_top_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic alu_we = 1'b0;
  logic [7:0] alu_result = 8'h00;
  logic [7:0] acc_out;
  logic [2:0] ptr_inc = 3'h0;
  logic branch_req = 1'b0;
  logic [14:0] branch_target = 15'h0;
  logic branch_taken;
  logic [15:0] pc_addr;
  logic bank_sel;
  logic [31:0] rv;
  logic se;
  logic tk;
  logic [15:0] pc;
  logic [11:0] ptrs [5] = '{12'h001, 12'h003, 12'h004, 12'h00d, 12'h00e};
  int n_errors = 0;
  int n_tests = 0;

  dmia_top dmia_top_inst (
    .CORE_CLK(core_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .ALU_WE(alu_we), .ALU_RESULT(alu_result), .ACC_OUT(acc_out),
    .PTR_INC(ptr_inc), .BRANCH_REQ(branch_req), .BRANCH_TARGET(branch_target),
    .BRANCH_TAKEN(branch_taken), .PC_ADDR(pc_addr), .BANK_SEL(bank_sel));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // ----------
  // Tasks
  // ----------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask

  // Called just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rv = prdata;
    se = pslverr;
    if (pready !== 1'b1) begin
      n_errors++;
      $display("unexpected pready: expected 1 seen %b", pready);
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, {18'h0, a, 2'b00}, d, 4'hf);
  endtask

  task automatic rdc(input string s, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, {18'h0, a, 2'b00}, 8'h00, 4'hf);
    chk(s, {24'h0, e}, rv);
    chk("no error", 32'h0, {31'h0, se});
  endtask

  task automatic core(input logic [2:0] i, input logic w, input logic [7:0] r, input logic b, input logic [14:0] t);
    ptr_inc <= i;
    alu_we <= w;
    alu_result <= r;
    branch_req <= b;
    branch_target <= t;
    @(posedge core_clk);
    ptr_inc <= 3'h0;
    alu_we <= 1'b0;
    branch_req <= 1'b0;
    #1;
    tk = branch_taken;
    pc = pc_addr;
    @(posedge core_clk);
  endtask

  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (ptrs[i]) rdc("pointer reset", ptrs[i], 8'h00);
    rdc("bank reset", 12'h00b, 8'h00);
    foreach (ptrs[i]) wr(ptrs[i], 8'h3c ^ 8'(i));
    foreach (ptrs[i]) rdc("pointer", ptrs[i], 8'h3c ^ 8'(i));
    $display("test registers done");
    wr(12'h1f0, 8'ha5);
    wr(12'h0f0, 8'h5a);
    rdc("ram sector 1", 12'h1f0, 8'ha5);
    rdc("ram sector 0", 12'h0f0, 8'h5a);
    wr(12'h004, 8'h01);
    wr(12'h003, 8'hf0);
    rdc("second port", 12'h002, 8'ha5);
    wr(12'h002, 8'hc3);
    rdc("ram by port", 12'h1f0, 8'hc3);
    wr(12'hf80, 8'h69);
    wr(12'h00e, 8'h0f);
    wr(12'h00d, 8'h80);
    rdc("third port", 12'h00c, 8'h69);
    wr(12'h001, 8'hf0);
    rdc("first port", 12'h000, 8'h5a);
    wr(12'h000, 8'h11);
    rdc("ram by first", 12'h0f0, 8'h11);
    rdc("ram sector 1", 12'h1f0, 8'hc3);
    wr(12'h001, 8'h02);
    rdc("port on port", 12'h000, 8'h00);
    wr(12'h000, 8'h77);
    rdc("ram kept", 12'h1f0, 8'hc3);
    $display("test indirect done");
    rdc("unused", 12'h010, 8'h00);
    wr(12'h02f, 8'hff);
    wr(12'h061, 8'hff);
    rdc("reserved", 12'h02f, 8'h00);
    rdc("reserved", 12'h061, 8'h00);
    wr(12'h001, 8'hff);
    core(3'b001, 1'b0, 8'h00, 1'b0, 15'h0);
    rdc("first wrap", 12'h001, 8'h00);
    wr(12'h003, 8'hff);
    wr(12'h004, 8'h02);
    core(3'b010, 1'b0, 8'h00, 1'b0, 15'h0);
    rdc("second wrap", 12'h003, 8'h00);
    rdc("second high", 12'h004, 8'h02);
    wr(12'h00d, 8'hff);
    core(3'b100, 1'b0, 8'h00, 1'b0, 15'h0);
    rdc("third wrap", 12'h00d, 8'h00);
    rdc("third high", 12'h00e, 8'h0f);
    $display("test special done");
    core(3'b000, 1'b1, 8'h9c, 1'b0, 15'h0);
    chk("acc out", 32'h9c, {24'h0, acc_out});
    rdc("acc", 12'h005, 8'h9c);
    wr(12'h00b, 8'hff);
    rdc("bank", 12'h00b, 8'h01);
    core(3'b000, 1'b0, 8'h00, 1'b1, 15'h1234);
    chk("pc bank 1", {16'h0, 1'b1, 15'h1234}, {16'h0, pc});
    chk("taken", 32'h1, {31'h0, tk});
    wr(12'h00b, 8'hfe);
    core(3'b000, 1'b0, 8'h00, 1'b1, 15'h7fff);
    chk("pc bank 0", {16'h0, 1'b0, 15'h7fff}, {16'h0, pc});
    $display("test core done");
    apb(1'b1, 32'h00004004, 8'h55, 4'hf);
    chk("slverr high", 32'h1, {31'h0, se});
    apb(1'b1, 32'h00000006, 8'h55, 4'hf);
    chk("slverr misaligned", 32'h1, {31'h0, se});
    apb(1'b1, 32'h00000004, 8'h66, 4'he);
    rdc("pointer kept", 12'h001, 8'h00);
    wr(12'h005, 8'h42);
    rdc("acc write", 12'h005, 8'h42);
    wr(12'h001, 8'h05);
    rdc("acc by port", 12'h000, 8'h42);
    chk("acc out", 32'h42, {24'h0, acc_out});
    $display("test errors done");
    test_done();
  end
endmodule

`default_nettype wire
